/* rtl/program_counter_return_stack.sv */
// Added by the designer: register access over APB and the register addresses.
`timescale 1ns/10ps
// Behaviour
// [RL1] Program counter is 21 bits wide.
// [RL2] Fetch beyond implemented memory returns zero.
// [RL3] Reset at 0000h, interrupts at 0008h/0018h.
// [RL4] Only low byte direct; upper bytes via latches.
// [RL5] Low byte write loads both latches.
// [RL6] Low byte read copies upper bytes out.
// [RL7] Bit zero fixed; step is two.
// [RL8] Calls, gotos, branches bypass the latches.
// [RL9] Stack is 31 by 21, 5-bit pointer.
// [RL10] Push increments pointer, then stores counter.
// [RL11] Return loads top entry, then decrements.
// [RL12] Calls and returns leave latches alone.
// [RL13] Every reset clears pointer; zero is empty.
// [RL14] Top registers access entry at pointer.
// [RL15] Thirty-one pushes set sticky full flag.
// [RL16] Error reset: 31st push stores, flags, resets.
// [RL17] No error reset: pointer stops at 31.
// [RL18] Empty pop loads zero, sets underflow.
// [RL19] Error reset option decides device reset.
// [RL20] Pointer register layout: full, underflow, pointer.
// [RL21] Push stores counter; pop only decrements.
// [RL22] Interrupt captures shadow; fast return restores.
// [RL23] Fast call saves, fast return restores.
// [RL24] Software masks interrupts during top access.
// [RL25] Interrupt wake pushes counter, loads vector.
// [RL26] Low byte write redirects the next fetch.
module program_counter_return_stack
	import pcs_pkg::*;
#(
	parameter logic [PC_W-1:0] PROG_MEM_BYTES = 21'h010000
) (
	input wire logic CLK_SYS,
	input wire logic RST,
	input wire logic CORE_RESET,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire core_op_t CORE_OP,
	input wire logic CORE_FAST,
	input wire logic CORE_IRQ_HIGH,
	input wire logic [PC_W-1:0] CORE_TARGET,
	input wire logic [SHADOW_W-1:0] CORE_STATUS,
	input wire logic [SHADOW_W-1:0] CORE_WORKING,
	input wire logic [SHADOW_W-1:0] CORE_BANK,
	output logic [PC_W-1:0] FETCH_ADDR,
	input wire logic [INSTR_W-1:0] MEM_DATA,
	output logic [INSTR_W-1:0] INSTR_WORD,
	output logic FLUSH,
	output logic SHADOW_RESTORE,
	output logic [SHADOW_W-1:0] SHADOW_STATUS,
	output logic [SHADOW_W-1:0] SHADOW_WORKING,
	output logic [SHADOW_W-1:0] SHADOW_BANK,
	output logic STACK_RESET_REQ
);
	stack_port_if stk ();

	//[RL9] 31 by 21 store
	return_stack_store #(
		.DEPTH(STACK_DEPTH)
	) u_store (
		.clk(CLK_SYS),
		.rst(RST),
		.port(stk)
	);

	// The counter keeps only bits 20:1; bit 0 cannot be anything but zero.
	logic [PC_W-1:1] pc_word;
	logic [PC_W-1:0] pc;
	logic [7:0] pc_high_latch;
	logic [4:0] pc_upper_latch;
	logic [SP_W-1:0] pointer_value;
	logic stack_full_flag;
	logic stack_underflow_flag;
	logic stack_error_reset_enable;
	logic reset_pending;
	logic [SHADOW_W-1:0] shadow_status;
	logic [SHADOW_W-1:0] shadow_working;
	logic [SHADOW_W-1:0] shadow_bank;

	logic apb_wr;
	logic apb_rd;
	logic addr_hit;
	logic [31:0] read_value;
	logic pcl_write;
	logic core_stack_op;
	logic [PC_W-1:1] next_pc_word;
	logic [SP_W-1:0] next_pointer;
	logic set_full;
	logic set_underflow;
	logic error_reset;
	logic core_wr_en;
	logic [PC_W-1:0] top_entry;

	function automatic logic [SP_W-1:0] ptr_inc(input logic [SP_W-1:0] p);
		ptr_inc = SP_W'(p + 1'b1);
	endfunction

	function automatic logic [PC_W-1:1] to_word(input logic [PC_W-1:0] byte_addr);
		to_word = byte_addr[PC_W-1:1];
	endfunction

	//[RL1] 21-bit counter
	assign pc = {pc_word, 1'b0};
	assign FETCH_ADDR = pc;
	assign top_entry = stk.rd_data;

	assign apb_wr = PSEL && PENABLE && PWRITE;
	assign apb_rd = PSEL && PENABLE && !PWRITE;
	assign PREADY = 1'b1;
	assign pcl_write = apb_wr && (PADDR == ADDR_PC_LOW);
	assign core_stack_op = (CORE_OP == OP_CALL) || (CORE_OP == OP_IRQ) || (CORE_OP == OP_PUSH)
		|| (CORE_OP == OP_RETURN) || (CORE_OP == OP_RETURN_IRQ) || (CORE_OP == OP_POP);

	always_comb begin
		case (PADDR)
			ADDR_POINTER, ADDR_TOP_LOW, ADDR_TOP_HIGH, ADDR_TOP_UPPER, ADDR_PC_LOW,
			ADDR_PC_HIGH_LATCH, ADDR_PC_UPPER_LATCH, ADDR_CONFIG: addr_hit = 1'b1;
			default: addr_hit = 1'b0;
		endcase
	end
	assign PSLVERR = PSEL && PENABLE && !addr_hit;

	//[RL14] top entry view
	//[RL20] pointer layout
	always_comb begin
		read_value = '0;
		case (PADDR)
			ADDR_POINTER: read_value = {24'h000000, stack_full_flag, stack_underflow_flag,
				1'b0, pointer_value};
			ADDR_TOP_LOW: read_value = {24'h000000, top_entry[7:0]};
			ADDR_TOP_HIGH: read_value = {24'h000000, top_entry[15:8]};
			ADDR_TOP_UPPER: read_value = {27'h0000000, top_entry[20:16]};
			ADDR_PC_LOW: read_value = {24'h000000, pc[7:0]};
			ADDR_PC_HIGH_LATCH: read_value = {24'h000000, pc_high_latch};
			ADDR_PC_UPPER_LATCH: read_value = {27'h0000000, pc_upper_latch};
			ADDR_CONFIG: read_value = {31'h00000000, stack_error_reset_enable};
			default: read_value = '0;
		endcase
	end

	// Read data is captured in the setup phase so the access phase needs no wait state.
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			PRDATA <= '0;
		end else if (PSEL && !PENABLE) begin
			PRDATA <= read_value;
		end
	end

	// Core sequencing: counter, pointer and stack write for one operation.
	always_comb begin
		next_pc_word = pc_word;
		next_pointer = pointer_value;
		set_full = 1'b0;
		set_underflow = 1'b0;
		error_reset = 1'b0;
		core_wr_en = 1'b0;
		case (CORE_OP)
			//[RL7] step by two
			OP_STEP: next_pc_word = pc_word + WORD_STEP;
			//[RL8] direct load
			OP_JUMP: next_pc_word = to_word(CORE_TARGET);
			OP_CALL, OP_IRQ, OP_PUSH: begin
				if (CORE_OP == OP_CALL) begin
					next_pc_word = to_word(CORE_TARGET);
				end else if (CORE_OP == OP_IRQ) begin
					//[RL25] vector on interrupt
					next_pc_word = to_word(CORE_IRQ_HIGH ? HIGH_VECTOR : LOW_VECTOR);
				end
				//[RL17] pointer stops at 31
				if (pointer_value == SP_MAX) begin
					set_full = 1'b1;
					error_reset = stack_error_reset_enable;
				end else begin
					//[RL10] increment then store
					next_pointer = ptr_inc(pointer_value);
					core_wr_en = 1'b1;
					//[RL15] full on 31st
					if (pointer_value == SP_LAST_FREE) begin
						set_full = 1'b1;
						//[RL16] error reset option
						error_reset = stack_error_reset_enable;
					end
				end
			end
			OP_RETURN, OP_RETURN_IRQ, OP_POP: begin
				if (pointer_value == SP_RESET) begin
					//[RL18] empty pop
					if (CORE_OP != OP_POP) begin
						next_pc_word = to_word(RESET_VECTOR);
					end
					set_underflow = 1'b1;
					//[RL19] reset when enabled
					error_reset = stack_error_reset_enable;
				end else begin
					//[RL11] load then decrement
					if (CORE_OP != OP_POP) begin
						next_pc_word = to_word(top_entry);
					end
					//[RL21] pop discards
					next_pointer = SP_W'(pointer_value - 1'b1);
				end
			end
			default: next_pc_word = pc_word;
		endcase
	end

	// Any core stack operation owns the single write port; a software top write in that cycle is dropped.
	always_comb begin
		stk.rd_idx = pointer_value;
		stk.wr_idx = next_pointer;
		stk.wr_data = pc;
		stk.wr_en = core_wr_en;
		if (!core_stack_op && apb_wr) begin
			stk.wr_idx = pointer_value;
			stk.wr_data = top_entry;
			case (PADDR)
				ADDR_TOP_LOW: stk.wr_data[7:0] = PWDATA[7:0];
				ADDR_TOP_HIGH: stk.wr_data[15:8] = PWDATA[7:0];
				ADDR_TOP_UPPER: stk.wr_data[20:16] = PWDATA[4:0];
				default: stk.wr_data = top_entry;
			endcase
			stk.wr_en = (PADDR == ADDR_TOP_LOW) || (PADDR == ADDR_TOP_HIGH)
				|| (PADDR == ADDR_TOP_UPPER);
		end
	end

	//[RL3] reset vector start
	always_ff @(posedge CLK_SYS) begin
		if (RST || CORE_RESET || reset_pending) begin
			pc_word <= to_word(RESET_VECTOR);
		end else if (pcl_write) begin
			//[RL5] latches into counter
			pc_word <= {pc_upper_latch, pc_high_latch, PWDATA[7:1]};
		end else begin
			pc_word <= next_pc_word;
		end
	end

	//[RL26] flush on redirect
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			FLUSH <= 1'b0;
		end else begin
			FLUSH <= pcl_write;
		end
	end

	//[RL4] latch-only upper access
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			pc_high_latch <= LATCH_RESET;
			pc_upper_latch <= LATCH_RESET[4:0];
		end else if (apb_wr && (PADDR == ADDR_PC_HIGH_LATCH)) begin
			pc_high_latch <= PWDATA[7:0];
		end else if (apb_wr && (PADDR == ADDR_PC_UPPER_LATCH)) begin
			pc_upper_latch <= PWDATA[4:0];
		end else if (apb_rd && (PADDR == ADDR_PC_LOW)) begin
			//[RL6] read copies upper
			pc_high_latch <= pc[15:8];
			pc_upper_latch <= pc[20:16];
		end
	end

	//[RL13] reset clears pointer
	always_ff @(posedge CLK_SYS) begin
		if (RST || CORE_RESET || reset_pending) begin
			pointer_value <= SP_RESET;
		end else if (core_stack_op) begin
			pointer_value <= next_pointer;
		end else if (apb_wr && (PADDR == ADDR_POINTER)) begin
			pointer_value <= PWDATA[SP_W-1:0];
		end
	end

	// Flags survive every reset but power-on; a hardware set beats a software clear.
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			stack_full_flag <= 1'b0;
			stack_underflow_flag <= 1'b0;
		end else begin
			stack_full_flag <= set_full || (stack_full_flag
				&& !(apb_wr && (PADDR == ADDR_POINTER) && !PWDATA[FULL_BIT]));
			stack_underflow_flag <= set_underflow || (stack_underflow_flag
				&& !(apb_wr && (PADDR == ADDR_POINTER) && !PWDATA[UNDERFLOW_BIT]));
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			stack_error_reset_enable <= CFG_STACK_RESET_DEFAULT;
		end else if (apb_wr && (PADDR == ADDR_CONFIG)) begin
			stack_error_reset_enable <= PWDATA[CFG_STACK_RESET_BIT];
		end
	end

	// The stack reset lands one cycle after the push or pop, so the 31st entry is kept.
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			reset_pending <= 1'b0;
			STACK_RESET_REQ <= 1'b0;
		end else begin
			reset_pending <= error_reset && !reset_pending;
			STACK_RESET_REQ <= error_reset && !reset_pending;
		end
	end

	//[RL22] interrupt shadow
	//[RL23] fast call shadow
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			shadow_status <= '0;
			shadow_working <= '0;
			shadow_bank <= '0;
		end else if ((CORE_OP == OP_IRQ) || ((CORE_OP == OP_CALL) && CORE_FAST)) begin
			shadow_status <= CORE_STATUS;
			shadow_working <= CORE_WORKING;
			shadow_bank <= CORE_BANK;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			SHADOW_RESTORE <= 1'b0;
			SHADOW_STATUS <= '0;
			SHADOW_WORKING <= '0;
			SHADOW_BANK <= '0;
		end else begin
			SHADOW_RESTORE <= CORE_FAST
				&& ((CORE_OP == OP_RETURN) || (CORE_OP == OP_RETURN_IRQ));
			SHADOW_STATUS <= shadow_status;
			SHADOW_WORKING <= shadow_working;
			SHADOW_BANK <= shadow_bank;
		end
	end

	//[RL2] zero beyond memory
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			INSTR_WORD <= '0;
		end else begin
			INSTR_WORD <= (pc >= PROG_MEM_BYTES) ? '0 : MEM_DATA;
		end
	end

	//[RL2] beyond check
	AST_BEYOND_ZERO: assert property (@(posedge CLK_SYS) disable iff (RST) // [RL2]
		(FETCH_ADDR >= PROG_MEM_BYTES) |=> (INSTR_WORD == '0))
		else $error("fetch beyond memory did not read zero");

	//[RL3] reset vector check
	AST_RESET_VECTOR: assert property (@(posedge CLK_SYS) // [RL3]
		$past(RST) |-> (FETCH_ADDR == RESET_VECTOR) && (pointer_value == SP_RESET))
		else $error("reset did not start at the reset vector");

	//[RL25] vector check
	AST_IRQ_VECTOR: assert property (@(posedge CLK_SYS) disable iff (RST) // [RL25]
		(CORE_OP == OP_IRQ) && !pcl_write && !CORE_RESET && !reset_pending && !error_reset
		|=> FETCH_ADDR == ($past(CORE_IRQ_HIGH) ? HIGH_VECTOR : LOW_VECTOR))
		else $error("interrupt did not load its vector");

	//[RL5] latch transfer check
	AST_PCL_WRITE: assert property (@(posedge CLK_SYS) disable iff (RST) // [RL5]
		pcl_write && !CORE_RESET && !reset_pending |=> FETCH_ADDR ==
		{$past(pc_upper_latch), $past(pc_high_latch), $past(PWDATA[7:1]), 1'b0} && FLUSH ##1 !FLUSH)
		else $error("low byte write did not load the latches");

	//[RL12] latches untouched
	AST_CALL_LATCHES: assert property (@(posedge CLK_SYS) disable iff (RST) // [RL12]
		core_stack_op && !PSEL |=> $stable(pc_high_latch) && $stable(pc_upper_latch))
		else $error("call or return changed a latch");

	//[RL10] push check
	AST_PUSH_STORE: assert property (@(posedge CLK_SYS) disable iff (RST) // [RL10]
		(CORE_OP == OP_CALL) && (pointer_value < SP_LAST_FREE) && !CORE_RESET && !reset_pending
		|=> (pointer_value == ptr_inc($past(pointer_value))) && (top_entry == $past(pc)))
		else $error("push did not increment and store the counter");

	//[RL18] underflow check
	AST_UNDERFLOW: assert property (@(posedge CLK_SYS) disable iff (RST) // [RL18]
		(CORE_OP == OP_RETURN) && (pointer_value == SP_RESET) && !pcl_write
		|=> stack_underflow_flag && (FETCH_ADDR == RESET_VECTOR) && (pointer_value == SP_RESET))
		else $error("empty pop did not flag underflow");

	//[RL15] sticky full
	AST_FULL_STICKY: assert property (@(posedge CLK_SYS) disable iff (RST) // [RL15]
		stack_full_flag && !(apb_wr && (PADDR == ADDR_POINTER)) |=> stack_full_flag)
		else $error("full flag dropped without a software clear");

	//[RL16] overflow reset
	AST_OVERFLOW_RESET: assert property (@(posedge CLK_SYS) disable iff (RST) // [RL16]
		(CORE_OP == OP_PUSH) && (pointer_value == SP_LAST_FREE) && stack_error_reset_enable
		&& !CORE_RESET && !reset_pending
		|=> STACK_RESET_REQ && stack_full_flag ##1 (pointer_value == SP_RESET) && stack_full_flag)
		else $error("31st push did not flag full and reset");

	//[RL22] shadow capture
	AST_SHADOW_CAPTURE: assert property (@(posedge CLK_SYS) disable iff (RST) // [RL22]
		(CORE_OP == OP_IRQ) |=> ##1 (SHADOW_STATUS == $past(CORE_STATUS, 2))
		&& (SHADOW_WORKING == $past(CORE_WORKING, 2)) && (SHADOW_BANK == $past(CORE_BANK, 2)))
		else $error("interrupt did not capture the shadow registers");
endmodule // program_counter_return_stack

/* rtl/pcs_pkg.sv */
package pcs_pkg;
	localparam int PC_W = 21;
	localparam int SP_W = 5;
	localparam int STACK_DEPTH = 31;
	localparam int INSTR_W = 16;
	localparam int SHADOW_W = 8;
	localparam logic [20:0] RESET_VECTOR = 21'h000000;
	localparam logic [20:0] HIGH_VECTOR = 21'h000008;
	localparam logic [20:0] LOW_VECTOR = 21'h000018;
	localparam logic [19:0] WORD_STEP = 20'h00001;
	localparam logic [4:0] SP_RESET = 5'h00;
	localparam logic [4:0] SP_MAX = 5'h1f;
	localparam logic [4:0] SP_LAST_FREE = 5'h1e;
	// Register byte addresses on the APB side.
	localparam logic [7:0] ADDR_POINTER = 8'h00;
	localparam logic [7:0] ADDR_TOP_LOW = 8'h04;
	localparam logic [7:0] ADDR_TOP_HIGH = 8'h08;
	localparam logic [7:0] ADDR_TOP_UPPER = 8'h0c;
	localparam logic [7:0] ADDR_PC_LOW = 8'h10;
	localparam logic [7:0] ADDR_PC_HIGH_LATCH = 8'h14;
	localparam logic [7:0] ADDR_PC_UPPER_LATCH = 8'h18;
	localparam logic [7:0] ADDR_CONFIG = 8'h1c;
	// Pointer and config register fields; reset values.
	localparam int FULL_BIT = 7;
	localparam int UNDERFLOW_BIT = 6;
	localparam int CFG_STACK_RESET_BIT = 0;
	localparam logic CFG_STACK_RESET_DEFAULT = 1'b1;
	localparam logic [7:0] LATCH_RESET = 8'h00;
	typedef enum logic [3:0] {
		OP_NONE = 4'b0000,
		OP_STEP = 4'b0001,
		OP_JUMP = 4'b0010,
		OP_CALL = 4'b0011,
		OP_RETURN = 4'b0100,
		OP_RETURN_IRQ = 4'b0101,
		OP_PUSH = 4'b0110,
		OP_POP = 4'b0111,
		OP_IRQ = 4'b1000
	} core_op_t;
endpackage

/* rtl/stack_port_if.sv */
`timescale 1ns/10ps
interface stack_port_if;
	import pcs_pkg::*;
	logic wr_en;
	logic [SP_W-1:0] wr_idx;
	logic [PC_W-1:0] wr_data;
	logic [SP_W-1:0] rd_idx;
	logic [PC_W-1:0] rd_data;
	modport ctrl (output wr_en, output wr_idx, output wr_data, output rd_idx, input rd_data);
	modport store (input wr_en, input wr_idx, input wr_data, input rd_idx, output rd_data);
endinterface

/* rtl/return_stack_store.sv */
`timescale 1ns/10ps
module return_stack_store
	import pcs_pkg::*;
#(
	parameter int DEPTH = STACK_DEPTH
) (
	input wire logic clk,
	input wire logic rst,
	stack_port_if.store port
);
	logic [PC_W-1:0] entry [1:DEPTH];

	function automatic logic idx_ok(input logic [SP_W-1:0] idx);
		idx_ok = (idx != SP_RESET) && (32'(idx) <= DEPTH);
	endfunction

	// Index zero has no storage behind it, so it always reads as zero.
	always_comb begin
		port.rd_data = '0;
		if (idx_ok(port.rd_idx)) begin
			port.rd_data = entry[port.rd_idx];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			for (int i = 1; i <= DEPTH; i++) begin
				entry[i] <= '0;
			end
		end else if (port.wr_en && idx_ok(port.wr_idx)) begin
			entry[port.wr_idx] <= port.wr_data;
		end
	end
endmodule // return_stack_store

/* verif/program_memory_model.sv */
`timescale 1ns/10ps
module program_memory_model
	import pcs_pkg::*;
(
	input wire logic [PC_W-1:0] addr,
	output logic [INSTR_W-1:0] data
);
	// Each word holds a pattern of address bits 16:1 and reads zero only where they equal 5a3ch, so a fetch
	// beyond the implemented memory from any other address only reads zero if the block masks it itself.
	assign data = addr[16:1] ^ 16'h5a3c;
endmodule // program_memory_model

/* verif/program_counter_return_stack_test.sv */
`timescale 1ns/10ps
`define CHK(what, e, g) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
	$display("mismatch %s expected %h seen %h", what, e, g); end end
module program_counter_return_stack_test;
	import pcs_pkg::*;
	localparam int MEM_BYTES = 'h10000;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic core_reset = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, flush, shadow_restore, stack_reset_req;
	core_op_t core_op = OP_NONE;
	logic core_fast = 1'b0, core_irq_high = 1'b0;
	logic [PC_W-1:0] core_target = 21'h0;
	logic [7:0] core_status = 8'h00, core_working = 8'h00, core_bank = 8'h00;
	logic [PC_W-1:0] fetch_addr;
	logic [INSTR_W-1:0] mem_data, instr_word;
	logic [7:0] sh_status, sh_working, sh_bank;
	int mismatches = 0, checks_done = 0, seed = 77340;
	int pc, sp, full, unf, cfg, rq, shadow;
	int stk[32];
	logic [31:0] rd;
	logic err, fl;
	core_op_t ops[4] = '{OP_STEP, OP_JUMP, OP_CALL, OP_RETURN};

	program_counter_return_stack #(.PROG_MEM_BYTES(21'h010000)) DUT (
		.CLK_SYS(clk_sys), .RST(rst), .CORE_RESET(core_reset), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .CORE_OP(core_op),
		.CORE_FAST(core_fast), .CORE_IRQ_HIGH(core_irq_high), .CORE_TARGET(core_target),
		.CORE_STATUS(core_status), .CORE_WORKING(core_working), .CORE_BANK(core_bank),
		.FETCH_ADDR(fetch_addr), .MEM_DATA(mem_data), .INSTR_WORD(instr_word),
		.FLUSH(flush), .SHADOW_RESTORE(shadow_restore), .SHADOW_STATUS(sh_status),
		.SHADOW_WORKING(sh_working), .SHADOW_BANK(sh_bank),
		.STACK_RESET_REQ(stack_reset_req)
	);
	program_memory_model MEM (.addr(fetch_addr), .data(mem_data));

	initial begin
		forever #4 clk_sys = ~clk_sys;
	end

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// Entered just after a rising edge; leaves one idle edge so strobes never toggle twice.
	task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= wdata;
		@(posedge clk_sys);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			mismatches++;
			report_and_stop();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		#1;
		fl = flush;
		@(posedge clk_sys);
	endtask

	task automatic push();
		if (sp == 31) begin
			full = 1;
			rq = cfg;
		end else begin
			sp++;
			stk[sp] = pc;
			if (sp == 31) begin
				full = 1;
				rq = cfg;
			end
		end
	endtask

	task automatic ret();
		if (sp == 0) begin
			unf = 1;
			pc = 0;
			rq = cfg;
		end else begin
			pc = stk[sp];
			sp--;
		end
	endtask

	task automatic core(input core_op_t op, input logic fast, input logic hi, input int tgt);
		int ei;
		int nsh;
		logic er;
		ei = (pc >= MEM_BYTES) ? 0 : (((pc >> 1) & 'hffff) ^ 'h5a3c);
		nsh = $random(seed) & 'hffffff;
		er = fast && (op == OP_RETURN || op == OP_RETURN_IRQ);
		core_op <= op;
		core_fast <= fast;
		core_irq_high <= hi;
		core_target <= tgt[20:0];
		{core_status, core_working, core_bank} <= nsh[23:0];
		rq = 0;
		if (op == OP_IRQ || (fast && op == OP_CALL)) shadow = nsh;
		case (op)
			OP_STEP: pc = (pc + 2) & 'h1ffffe;
			OP_JUMP: pc = tgt & 'h1ffffe;
			OP_CALL: begin
				push();
				pc = tgt & 'h1ffffe;
			end
			OP_IRQ: begin
				push();
				pc = hi ? 'h8 : 'h18;
			end
			OP_PUSH: push();
			OP_POP: if (sp > 0) begin
				sp--;
			end else begin
				unf = 1;
				rq = cfg;
			end
			OP_RETURN, OP_RETURN_IRQ: ret();
			default: ;
		endcase
		@(posedge clk_sys);
		core_op <= OP_NONE;
		#1;
		`CHK("fetch_addr", pc, fetch_addr)
		`CHK("instr_word", ei, instr_word)
		`CHK("stack_reset_req", rq, stack_reset_req)
		`CHK("shadow_restore", er, shadow_restore)
		if (er) `CHK("shadow", shadow, {sh_status, sh_working, sh_bank})
		@(posedge clk_sys);
		if (rq) begin
			sp = 0;
			pc = 0;
		end
	endtask

	task automatic wptr(input int v);
		apb(1'b1, ADDR_POINTER, v);
		full &= (v >> 7) & 1;
		unf &= (v >> 6) & 1;
		sp = v & 31;
	endtask

	task automatic check_state();
		apb(1'b0, ADDR_POINTER, 32'h0);
		`CHK("pointer", (full << 7) | (unf << 6) | sp, rd)
		`CHK("slverr", 0, err)
		`CHK("fetch_addr", pc, fetch_addr)
	endtask

	task automatic por();
		rst <= 1'b1;
		repeat (16) @(posedge clk_sys);
		rst <= 1'b0;
		pc = 0;
		sp = 0;
		full = 0;
		unf = 0;
		cfg = 1;
	endtask

	initial begin
		int k;
		por();
		check_state();
		apb(1'b0, ADDR_CONFIG, 32'h0);
		`CHK("config", 1, rd)
		apb(1'b0, 8'h20, 32'h0);
		`CHK("unmapped error", 1, err)
		`CHK("unmapped data", 0, rd)
		cfg = 0;
		apb(1'b1, ADDR_CONFIG, 32'h0);
		repeat (3) core(OP_STEP, 1'b0, 1'b0, 0);
		core(OP_JUMP, 1'b0, 1'b0, 'h1ffff3);
		core(OP_STEP, 1'b0, 1'b0, 0);
		core(OP_IRQ, 1'b0, 1'b1, 0);
		core(OP_IRQ, 1'b0, 1'b0, 0);
		check_state();
		core(OP_RETURN_IRQ, 1'b1, 1'b0, 0);
		core(OP_RETURN_IRQ, 1'b0, 1'b0, 0);
		core(OP_CALL, 1'b1, 1'b0, $random(seed));
		core(OP_RETURN, 1'b1, 1'b0, 0);
		for (int i = 0; i < 40; i++) begin
			k = $random(seed) & 3;
			core(ops[k], 1'b0, 1'b0, $random(seed));
			check_state();
		end
		core(OP_CALL, 1'b0, 1'b0, 'h2468);
		// core held idle while the top entry is touched
		apb(1'b0, ADDR_TOP_LOW, 32'h0);
		`CHK("top low", stk[sp] & 'hff, rd)
		apb(1'b0, ADDR_TOP_HIGH, 32'h0);
		`CHK("top high", (stk[sp] >> 8) & 'hff, rd)
		apb(1'b0, ADDR_TOP_UPPER, 32'h0);
		`CHK("top upper", stk[sp] >> 16, rd)
		apb(1'b1, ADDR_TOP_LOW, 32'h5a);
		stk[sp] = (stk[sp] & 'h1fff00) | 'h5a;
		core(OP_RETURN, 1'b0, 1'b0, 0);
		apb(1'b1, ADDR_PC_HIGH_LATCH, 32'hc3);
		apb(1'b1, ADDR_PC_UPPER_LATCH, 32'h15);
		apb(1'b1, ADDR_PC_LOW, 32'h77);
		pc = 'h15c376;
		`CHK("flush", 1, fl)
		check_state();
		core(OP_CALL, 1'b0, 1'b0, 'h0abcd0);
		core(OP_RETURN, 1'b0, 1'b0, 0);
		apb(1'b0, ADDR_PC_HIGH_LATCH, 32'h0);
		`CHK("high latch", 'hc3, rd)
		core(OP_JUMP, 1'b0, 1'b0, 'h1a2b3c);
		apb(1'b0, ADDR_PC_LOW, 32'h0);
		`CHK("pc low", 'h3c, rd)
		apb(1'b0, ADDR_PC_HIGH_LATCH, 32'h0);
		`CHK("high latch", 'h2b, rd)
		apb(1'b0, ADDR_PC_UPPER_LATCH, 32'h0);
		`CHK("upper latch", 'h1a, rd)
		wptr(0);
		repeat (30) core(OP_PUSH, 1'b0, 1'b0, 0);
		check_state();
		core(OP_PUSH, 1'b0, 1'b0, 0);
		// A new counter value makes an overwrite of the last entry visible.
		core(OP_JUMP, 1'b0, 1'b0, 'h0246);
		core(OP_PUSH, 1'b0, 1'b0, 0);
		check_state();
		apb(1'b0, ADDR_TOP_LOW, 32'h0);
		`CHK("kept entry", stk[31] & 'hff, rd)
		core(OP_POP, 1'b0, 1'b0, 0);
		check_state();
		wptr('hc3);
		check_state();
		cfg = 1;
		apb(1'b1, ADDR_CONFIG, 32'h1);
		wptr(0);
		repeat (31) core(OP_PUSH, 1'b0, 1'b0, 0);
		check_state();
		wptr('hdf);
		apb(1'b0, ADDR_TOP_LOW, 32'h0);
		`CHK("last entry", stk[31] & 'hff, rd)
		wptr('hc0);
		core(OP_RETURN, 1'b0, 1'b0, 0);
		check_state();
		core(OP_CALL, 1'b0, 1'b0, 'h3000);
		core_reset <= 1'b1;
		@(posedge clk_sys);
		core_reset <= 1'b0;
		@(posedge clk_sys);
		sp = 0;
		pc = 0;
		check_state();
		por();
		check_state();
		report_and_stop();
	end
endmodule // program_counter_return_stack_test
